// ### hdl/ffs_pkg.sv
// Package for the framer format and sleep control block
package ffs_pkg;
  localparam logic [6:0]  ADDR_VCO_CAL   = 7'h17;
  localparam logic [6:0]  ADDR_REG_SLEEP = 7'h1b;
  localparam logic [6:0]  ADDR_REVISION  = 7'h1d;
  localparam logic [6:0]  ADDR_SIGNATURE = 7'h1e;
  localparam logic [6:0]  ADDR_SILICON   = 7'h1f;
  localparam logic [6:0]  ADDR_PKT_FMT   = 7'h20;
  localparam logic [6:0]  ADDR_SLEEP     = 7'h23;
  localparam logic [6:0]  ADDR_SYNC0     = 7'h24;
  localparam logic [6:0]  ADDR_SYNC1     = 7'h25;
  localparam logic [6:0]  ADDR_SYNC2     = 7'h26;
  localparam logic [6:0]  ADDR_SYNC3     = 7'h27;
  localparam int          VCO_CAL_BIT    = 2;
  localparam int          REG_SLEEP_LSB  = 11;
  localparam int          SLEEP_BIT      = 14;
  localparam int          KEEP_ALIVE_BIT = 12;
  localparam logic [15:0] VCO_CAL_RESET  = 16'h0000;
  localparam logic [4:0]  REG_SLEEP_RESET = 5'h00;
  localparam logic [15:0] PKT_FMT_RESET  = 16'h5806;
  localparam logic [15:0] PKT_FMT_MASK   = 16'hfffe;
  localparam logic [15:0] SYNC_RESET     = 16'h0000;
  // Arbitrary neutral identity values
  localparam logic [15:0] SIGNATURE_DEF  = 16'h5a5a;
  localparam logic [15:0] SILICON_DEF    = 16'h0101;
  localparam logic [3:0]  RADIO_REV_DEF  = 4'h1;
  localparam logic [2:0]  DIGITAL_REV_DEF = 3'h1;
  localparam int          CLK_HZ         = 50_000_000;
  localparam int          TXBIT_HZ       = 1_000_000;
  localparam int          TXBIT_HALF     = CLK_HZ / TXBIT_HZ / 2;

  typedef struct packed {
    logic [2:0] preamble_length_select;
    logic [1:0] sync_pattern_length;
    logic [2:0] tail_bits_length;
    logic [1:0] line_coding;
    logic [1:0] error_correction_type;
    logic [2:0] clock_output_select;
    logic       rsvd;
  } ffs_fmt_t;

  typedef struct packed {
    logic [3:0] preamble_bytes;
    logic [6:0] sync_bits;
    logic [4:0] tail_bits;
    logic       nrz;
    logic       rate_two_thirds_code;
    logic       vco_autocal_enable;
  } ffs_frame_cfg_t;
endpackage

// ### hdl/ffs_spi_slave.sv
// SPI mode 0 slave framing 16-bit words after a command byte
`timescale 1ns/1ps
`default_nettype none
module ffs_spi_slave (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Synchronised pins
  input  wire logic        ss_b,
  input  wire logic        sck,
  input  wire logic        mosi,
  output logic             miso,
  // Register side
  output logic [6:0]       addr,
  output logic             rd_cmd,
  output logic             wr_stb,
  output logic [15:0]      wr_data,
  input  wire logic [15:0] rd_data
);
  logic        sck_d_ff;
  logic [4:0]  cnt_ff;
  logic [23:0] sh_ff;
  logic [15:0] tx_ff;
  logic        rd_ff;
  logic [6:0]  addr_ff;
  logic        wr_ff;
  logic        rise;
  logic        fall;
  logic [23:0] nxt_sh;
  assign rise   = sck & ~sck_d_ff;
  assign fall   = ~sck & sck_d_ff;
  assign nxt_sh = {sh_ff[22:0], mosi};
  assign addr   = addr_ff;
  assign rd_cmd = rd_ff;
  assign wr_stb = wr_ff;
  assign wr_data = sh_ff[15:0];
  assign miso   = tx_ff[15];
  // Command byte: bit 7 high is a read, low bits the address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_d_ff <= 1'b0;
      cnt_ff   <= 5'h00;
      sh_ff    <= 24'h000000;
      tx_ff    <= 16'h0000;
      rd_ff    <= 1'b0;
      addr_ff  <= 7'h00;
      wr_ff    <= 1'b0;
    end else begin
      sck_d_ff <= sck;
      wr_ff    <= 1'b0;
      if (ss_b) begin
        cnt_ff <= 5'h00;
      end else if (rise) begin
        sh_ff  <= nxt_sh;
        cnt_ff <= (cnt_ff == 5'd23) ? 5'd8 : cnt_ff + 5'd1;
        if (cnt_ff == 5'd7) begin
          rd_ff   <= nxt_sh[7];
          addr_ff <= nxt_sh[6:0];
        end
        if (cnt_ff == 5'd23 && !rd_ff) begin
          wr_ff <= 1'b1;
        end
      end else if (fall) begin
        if (cnt_ff == 5'd8) begin
          tx_ff <= rd_data;
        end else begin
          tx_ff <= {tx_ff[14:0], 1'b0};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### hdl/ffs_top.sv
// Framer format, identity and sleep control registers
`timescale 1ns/1ps
`default_nettype none
module ffs_top
  import ffs_pkg::*;
(
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RST_B,
  // SPI slave pins
  input  wire logic                    SPI_SS_B,
  input  wire logic                    SPI_SCK,
  input  wire logic                    SPI_MOSI,
  output logic                         SPI_MISO,
  // Radio status inputs
  input  wire logic                    TXRX_START,
  input  wire logic                    SYNTH_CLOCK,
  // Sync serialiser
  input  wire logic                    SYNC_LOAD,
  input  wire logic                    SYNC_SHIFT,
  output logic                         SYNC_BIT,
  // Framing and power outputs
  output ffs_pkg::ffs_frame_cfg_t      FRAME_CFG,
  output logic                         VCO_CAL_START,
  output logic [4:0]                   REGULATOR_SLEEP_CURRENT,
  output logic                         REGULATOR_SLEEP_APPLY,
  output logic                         CRYSTAL_GAIN_ON,
  output logic                         CRYSTAL_RUN,
  output logic                         SLEEPING,
  output logic                         AUX_CLOCK_OUT
);
  import ffs_pkg::*;

  logic [1:0]  ss_sync_ff;
  logic [1:0]  sck_sync_ff;
  logic [1:0]  mosi_sync_ff;
  logic [1:0]  synth_sync_ff;
  logic [6:0]  addr;
  logic        rd_cmd;
  logic        wr_stb;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [15:0] vco_ff;
  logic [4:0]  reg_sleep_ff;
  ffs_fmt_t    fmt_ff;
  logic        keep_alive_ff;
  logic        sleep_ff;
  logic        ss_d_ff;
  logic        ss_fall;
  logic [15:0] sync_ff [4];
  logic [63:0] sync_sh_ff;
  logic [6:0]  sync_cnt_ff;
  logic        div2_ff;
  logic [1:0]  div4_ff;
  logic [3:0]  div12_ff;
  logic        clk12_ff;
  logic [4:0]  txb_cnt_ff;
  logic        txb_ff;
  logic        aux_ff;
  logic        cal_ff;
  logic        nxt_aux;
  logic [63:0] sync_word;
  logic        wr_vco;
  logic        wr_rsleep;
  logic        wr_fmt;
  logic        wr_sleep;
  logic [15:0] rev_word;
  logic [15:0] sleep_rd;

  ffs_spi_slave u_spi (
    .clk     (CLK),
    .rst_b   (RST_B),
    .ss_b    (ss_sync_ff[1]),
    .sck     (sck_sync_ff[1]),
    .mosi    (mosi_sync_ff[1]),
    .miso    (SPI_MISO),
    .addr    (addr),
    .rd_cmd  (rd_cmd),
    .wr_stb  (wr_stb),
    .wr_data (wr_data),
    .rd_data (rd_data)
  );

  // SPI pins and SYNTH_CLOCK pass two flops before use
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ss_sync_ff    <= 2'b11;
      sck_sync_ff   <= 2'b00;
      mosi_sync_ff  <= 2'b00;
      synth_sync_ff <= 2'b00;
    end else begin
      ss_sync_ff    <= {ss_sync_ff[0], SPI_SS_B};
      sck_sync_ff   <= {sck_sync_ff[0], SPI_SCK};
      mosi_sync_ff  <= {mosi_sync_ff[0], SPI_MOSI};
      synth_sync_ff <= {synth_sync_ff[0], SYNTH_CLOCK};
    end
  end

  // Write decode
  assign wr_vco    = wr_stb && addr == ADDR_VCO_CAL;
  assign wr_rsleep = wr_stb && addr == ADDR_REG_SLEEP;
  assign wr_fmt    = wr_stb && addr == ADDR_PKT_FMT;
  assign wr_sleep  = wr_stb && addr == ADDR_SLEEP;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      vco_ff        <= VCO_CAL_RESET;
      reg_sleep_ff  <= REG_SLEEP_RESET;
      fmt_ff        <= PKT_FMT_RESET;
      keep_alive_ff <= 1'b1;
    end else begin
      if (wr_vco) begin
        vco_ff <= wr_data & (16'h0001 << VCO_CAL_BIT);
      end
      if (wr_rsleep) begin
        reg_sleep_ff <= wr_data[REG_SLEEP_LSB +: 5];
      end
      if (wr_fmt) begin
        fmt_ff <= wr_data & PKT_FMT_MASK;
      end
      if (wr_sleep) begin
        keep_alive_ff <= wr_data[KEEP_ALIVE_BIT];
      end
    end
  end

  // Wake on the select falling edge only; a level test would drop the
  // sleep write, which always lands while select is still low
  assign ss_fall = ss_d_ff & ~ss_sync_ff[1];
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ss_d_ff <= 1'b1;
    end else begin
      ss_d_ff <= ss_sync_ff[1];
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sleep_ff <= 1'b0;
    end else if (ss_fall) begin
      sleep_ff <= 1'b0;
    end else if (wr_sleep) begin
      sleep_ff <= wr_data[SLEEP_BIT];
    end
  end

  // Sync registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 4; i++) begin
        sync_ff[i] <= SYNC_RESET;
      end
    end else if (wr_stb && addr[6:2] == ADDR_SYNC0[6:2]) begin
      sync_ff[addr[1:0]] <= wr_data;
    end
  end

  always_comb begin
    unique case (fmt_ff.sync_pattern_length)
      2'b11: sync_word = {sync_ff[3], sync_ff[2], sync_ff[1], sync_ff[0]};
      2'b10: sync_word = {16'h0000, sync_ff[3], sync_ff[2], sync_ff[0]};
      2'b01: sync_word = {32'h00000000, sync_ff[3], sync_ff[0]};
      2'b00: sync_word = {48'h000000000000, sync_ff[0]};
    endcase
  end

  // LSB first serialiser
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync_sh_ff  <= 64'h0;
      sync_cnt_ff <= 7'h00;
    end else if (SYNC_LOAD) begin
      sync_sh_ff  <= sync_word;
      sync_cnt_ff <= FRAME_CFG.sync_bits;
    end else if (SYNC_SHIFT && sync_cnt_ff != 7'h00) begin
      sync_sh_ff  <= {1'b0, sync_sh_ff[63:1]};
      sync_cnt_ff <= sync_cnt_ff - 7'd1;
    end
  end
  assign SYNC_BIT = sync_sh_ff[0];

  // Derived frame settings
  assign FRAME_CFG.preamble_bytes = {1'b0, fmt_ff.preamble_length_select} + 4'd1;
  assign FRAME_CFG.sync_bits = {fmt_ff.sync_pattern_length, 4'h0} + 7'd16;
  assign FRAME_CFG.tail_bits = {1'b0, fmt_ff.tail_bits_length, 1'b0} + 5'd4;
  assign FRAME_CFG.nrz = fmt_ff.line_coding == 2'b00;
  assign FRAME_CFG.rate_two_thirds_code = fmt_ff.error_correction_type == 2'b10;
  assign FRAME_CFG.vco_autocal_enable = vco_ff[VCO_CAL_BIT];

  // Calibration pulse at each operation start while the VCO_CAL_BIT enable is set
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cal_ff <= 1'b0;
    end else begin
      cal_ff <= TXRX_START & vco_ff[VCO_CAL_BIT];
    end
  end
  assign VCO_CAL_START = cal_ff;

  // Power outputs
  assign SLEEPING                = sleep_ff;
  assign REGULATOR_SLEEP_CURRENT = reg_sleep_ff;
  assign REGULATOR_SLEEP_APPLY   = sleep_ff;
  assign CRYSTAL_GAIN_ON         = ~sleep_ff;
  assign CRYSTAL_RUN             = ~sleep_ff | keep_alive_ff;

  // Clock dividers; CLK stands for the crystal
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      div2_ff    <= 1'b0;
      div4_ff    <= 2'b00;
      div12_ff   <= 4'h0;
      clk12_ff   <= 1'b0;
      txb_cnt_ff <= 5'h00;
      txb_ff     <= 1'b0;
      aux_ff     <= 1'b0;
    end else begin
      div2_ff  <= ~div2_ff;
      div4_ff  <= div4_ff + 2'd1;
      div12_ff <= (div12_ff == 4'd5) ? 4'd0 : div12_ff + 4'd1;
      if (div12_ff == 4'd5) begin
        clk12_ff <= ~clk12_ff;
      end
      if (txb_cnt_ff == 5'(TXBIT_HALF - 1)) begin
        txb_cnt_ff <= 5'h00;
        txb_ff     <= ~txb_ff;
      end else begin
        txb_cnt_ff <= txb_cnt_ff + 5'd1;
      end
      aux_ff <= nxt_aux;
    end
  end

  // Buffered crystal is approximated by a half-rate registered copy
  always_comb begin
    unique case (fmt_ff.clock_output_select)
      3'b001:  nxt_aux = div2_ff;
      3'b010:  nxt_aux = div2_ff;
      3'b011:  nxt_aux = div4_ff[1];
      3'b100:  nxt_aux = clk12_ff;
      3'b101:  nxt_aux = txb_ff;
      3'b110:  nxt_aux = synth_sync_ff[1];
      default: nxt_aux = 1'b0;
    endcase
  end
  assign AUX_CLOCK_OUT = aux_ff & ~(sleep_ff & ~keep_alive_ff);

  // Read mux; sleep bit is write-only
  assign rev_word = {8'h00, RADIO_REV_DEF, 1'b0, DIGITAL_REV_DEF};
  assign sleep_rd = 16'h0001 << KEEP_ALIVE_BIT & {16{keep_alive_ff}};
  always_comb begin
    unique case (addr)
      ADDR_VCO_CAL:   rd_data = vco_ff;
      ADDR_REG_SLEEP: rd_data = {reg_sleep_ff, 11'h000};
      ADDR_REVISION:  rd_data = rev_word;
      ADDR_SIGNATURE: rd_data = SIGNATURE_DEF;
      ADDR_SILICON:   rd_data = SILICON_DEF;
      ADDR_PKT_FMT:   rd_data = fmt_ff;
      ADDR_SLEEP:     rd_data = sleep_rd;
      ADDR_SYNC0:     rd_data = sync_ff[0];
      ADDR_SYNC1:     rd_data = sync_ff[1];
      ADDR_SYNC2:     rd_data = sync_ff[2];
      ADDR_SYNC3:     rd_data = sync_ff[3];
      default:        rd_data = 16'h0000;
    endcase
  end

  logic unused_rd;
  assign unused_rd = rd_cmd;
endmodule
`default_nettype wire

// ### test/ffs_host_model.sv
// Host SPI master model, mode 0, one word per frame
`timescale 1ns/1ps
`default_nettype none
module ffs_host_model (
  // Clock and pins
  input  wire logic clk,
  output logic      ss_b,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    ss_b = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
  end
  // Five cycles per half period, above the slave's minimum of three
  task automatic half();
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd};
    ss_b = 1'b0;
    for (int i = 0; i < 24; i++) begin
      mosi = sh[23];
      sh = sh << 1;
      half();
      sck = 1'b1;
      rd = {rd[14:0], miso};
      half();
      sck = 1'b0;
    end
    half();
    // Data line stops meaning anything once the frame is over
    mosi = ~mosi;
    ss_b = 1'b1;
    half();
  endtask
endmodule
`default_nettype wire

// ### test/ffs_top_properties.sv
// Concurrent checks on the format and sleep block ports
`timescale 1ns/1ps
`default_nettype none
module ffs_top_properties
  import ffs_pkg::*;
(
  // Clock and reset
  input wire logic                     CLK,
  input wire logic                     RST_B,
  // Observed ports
  input wire logic                     SPI_SS_B,
  input wire logic                     TXRX_START,
  input wire ffs_pkg::ffs_frame_cfg_t  FRAME_CFG,
  input wire logic                     VCO_CAL_START,
  input wire logic                     REGULATOR_SLEEP_APPLY,
  input wire logic                     CRYSTAL_GAIN_ON,
  input wire logic                     CRYSTAL_RUN,
  input wire logic                     SLEEPING
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_cal_on;
    TXRX_START && FRAME_CFG.vco_autocal_enable |=> VCO_CAL_START;
  endproperty
  a_cal_on: assert property (p_cal_on) else $error("calibration start missing");
  property p_cal_off;
    TXRX_START && !FRAME_CFG.vco_autocal_enable |=> !VCO_CAL_START;
  endproperty
  a_cal_off: assert property (p_cal_off) else $error("calibration not skipped");
  property p_cal_cause;
    VCO_CAL_START |-> $past(TXRX_START);
  endproperty
  a_cal_cause: assert property (p_cal_cause) else $error("calibration without start");
  property p_apply;
    REGULATOR_SLEEP_APPLY == SLEEPING;
  endproperty
  a_apply: assert property (p_apply) else $error("sleep current not tied to sleep");
  property p_gain;
    CRYSTAL_GAIN_ON == !SLEEPING;
  endproperty
  a_gain: assert property (p_gain) else $error("crystal gain wrong for state");
  property p_run;
    !SLEEPING |-> CRYSTAL_RUN;
  endproperty
  a_run: assert property (p_run) else $error("crystal stopped while awake");
  // Two sync flops on the select pin, so a few cycles of slack
  property p_wake;
    SLEEPING && $fell(SPI_SS_B) |-> ##[1:6] !SLEEPING;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on select low");
  property p_preamble;
    FRAME_CFG.preamble_bytes inside {[1:8]};
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble length out of range");
  property p_sync;
    FRAME_CFG.sync_bits inside {16, 32, 48, 64};
  endproperty
  a_sync: assert property (p_sync) else $error("sync length not a legal size");
  property p_tail;
    FRAME_CFG.tail_bits inside {[4:18]} && !FRAME_CFG.tail_bits[0];
  endproperty
  a_tail: assert property (p_tail) else $error("trailer length out of range");
endmodule
bind ffs_top ffs_top_properties i_ffs_top_properties (.CLK(CLK), .RST_B(RST_B),
  .SPI_SS_B(SPI_SS_B), .TXRX_START(TXRX_START), .FRAME_CFG(FRAME_CFG),
  .VCO_CAL_START(VCO_CAL_START), .REGULATOR_SLEEP_APPLY(REGULATOR_SLEEP_APPLY),
  .CRYSTAL_GAIN_ON(CRYSTAL_GAIN_ON), .CRYSTAL_RUN(CRYSTAL_RUN), .SLEEPING(SLEEPING));
`default_nettype wire

// ### test/test_ffs_top.sv
// Self-checking bench for the format, identity and sleep block
`timescale 1ns/1ps
`default_nettype none
module test_ffs_top;
  import ffs_pkg::*;
  logic clk, rst_b, ss_b, sck, mosi, miso, txrx, synth, sload, sshift;
  logic sbit, cal, apply, gain, run, slp, aux;
  logic [4:0] cur;
  ffs_frame_cfg_t cfg;
  int fail_count, checked;
  ffs_top i_ffs_top (.CLK(clk), .RST_B(rst_b), .SPI_SS_B(ss_b), .SPI_SCK(sck),
    .SPI_MOSI(mosi), .SPI_MISO(miso), .TXRX_START(txrx), .SYNTH_CLOCK(synth),
    .SYNC_LOAD(sload), .SYNC_SHIFT(sshift), .SYNC_BIT(sbit), .FRAME_CFG(cfg),
    .VCO_CAL_START(cal), .REGULATOR_SLEEP_CURRENT(cur), .REGULATOR_SLEEP_APPLY(apply),
    .CRYSTAL_GAIN_ON(gain), .CRYSTAL_RUN(run), .SLEEPING(slp), .AUX_CLOCK_OUT(aux));
  ffs_host_model i_ffs_host_model (.clk(clk), .ss_b(ss_b), .sck(sck), .mosi(mosi),
    .miso(miso));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Slow synthesizer stand-in, period six cycles
  initial begin
    synth = 1'b0;
    forever begin
      repeat (3) @(posedge clk);
      #1 synth = ~synth;
    end
  end
  task automatic summarize();
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input int c, input int lo, input int hi);
    chk(16'(c >= lo && c <= hi), 16'h0001);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] x;
    i_ffs_host_model.xfer({1'b0, a}, d, x);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] d;
    i_ffs_host_model.xfer({1'b1, a}, 16'h0000, d);
    chk(d, e);
  endtask
  task automatic t_reset();
    chk(16'({gain, run}), 16'h0003);
    chk(16'({cfg.preamble_bytes, cfg.tail_bits}), 16'h0064);
    chk(16'({cfg.sync_bits, cfg.nrz, cfg.rate_two_thirds_code}), 16'h0102);
    rd_chk(ADDR_PKT_FMT, 16'h5806);
    rd_chk(ADDR_VCO_CAL, VCO_CAL_RESET);
    rd_chk(ADDR_REG_SLEEP, {REG_SLEEP_RESET, 11'h000});
    rd_chk(ADDR_SLEEP, 16'h1000);
    rd_chk(ADDR_SIGNATURE, SIGNATURE_DEF);
  endtask
  task automatic t_ro();
    wr(ADDR_REVISION, 16'hffff);
    wr(ADDR_SILICON, 16'h0000);
    wr(7'h7f, 16'hffff);
    rd_chk(ADDR_REVISION, {8'h00, RADIO_REV_DEF, 1'b0, DIGITAL_REV_DEF});
    rd_chk(ADDR_SILICON, SILICON_DEF);
    rd_chk(7'h7f, 16'h0000);
  endtask
  task automatic t_format();
    logic [2:0] c;
    logic [1:0] f;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      f = {c[0], 1'b0};
      wr(ADDR_PKT_FMT, {c, c[1:0], c, 2'b00, f, 3'b011, 1'b1});
      rd_chk(ADDR_PKT_FMT, {c, c[1:0], c, 2'b00, f, 3'b011, 1'b0});
      chk(16'(cfg.preamble_bytes), 16'(c) + 16'h0001);
      chk(16'(cfg.sync_bits), 16'({c[1:0], 4'h0}) + 16'h0010);
      chk(16'(cfg.tail_bits), 16'({c, 1'b0}) + 16'h0004);
      chk(16'({cfg.nrz, cfg.rate_two_thirds_code}), 16'({1'b1, c[0]}));
    end
  endtask
  task automatic t_vco(input logic [15:0] v);
    wr(ADDR_VCO_CAL, v);
    rd_chk(ADDR_VCO_CAL, v & 16'h0004);
    @(posedge clk);
    #1 txrx = 1'b1;
    @(posedge clk);
    #1 txrx = 1'b0;
    chk(16'(cal), 16'(v[2]));
    @(posedge clk);
    #1 chk(16'(cal), 16'h0000);
  endtask
  task automatic t_sync();
    logic [31:0] got;
    wr(ADDR_SYNC0, 16'h8421);
    wr(ADDR_SYNC1, 16'hffff);
    wr(ADDR_SYNC2, 16'hffff);
    wr(ADDR_SYNC3, 16'hc3a5);
    wr(ADDR_PKT_FMT, 16'h4806);
    @(posedge clk);
    #1 sload = 1'b1;
    @(posedge clk);
    #1 sload = 1'b0;
    sshift = 1'b1;
    for (int i = 0; i < 32; i++) begin
      got[i] = sbit;
      @(posedge clk);
      #1;
    end
    sshift = 1'b0;
    chk(got[15:0], 16'h8421);
    chk(got[31:16], 16'hc3a5);
  endtask
  task automatic rises(input int n, output int c);
    logic p;
    c = 0;
    p = aux;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (aux && !p) c++;
      p = aux;
    end
  endtask
  task automatic t_sleep();
    int c;
    wr(ADDR_REG_SLEEP, 16'hffff);
    chk(16'(cur), 16'h001f);
    wr(ADDR_SLEEP, 16'h5000);
    chk(16'({slp, apply, gain, run}), 16'h000d);
    rd_chk(ADDR_REG_SLEEP, 16'hf800);
    chk(16'(slp), 16'h0000);
    wr(ADDR_SLEEP, 16'h4000);
    chk(16'({slp, run}), 16'h0002);
    rises(120, c);
    chk_rng(c, 0, 0);
    rd_chk(ADDR_SLEEP, 16'h0000);
  endtask
  task automatic t_aux();
    int lo[8] = '{0, 59, 59, 29, 9, 2, 18, 0};
    int hi[8] = '{0, 61, 61, 31, 11, 3, 22, 0};
    int c;
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_PKT_FMT, 16'h5800 | 16'({s[2:0], 1'b0}));
      rises(120, c);
      chk_rng(c, lo[s], hi[s]);
    end
  endtask
  // Whole run is near 13.4k cycles; the limit leaves ample margin
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial begin
    rst_b = 1'b0;
    txrx = 1'b0;
    sload = 1'b0;
    sshift = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_ro();
    t_format();
    t_vco(16'hffff);
    t_vco(16'h0000);
    t_sync();
    t_sleep();
    t_aux();
    summarize();
  end
endmodule
`default_nettype wire
